// [hw/riaf_pkg.sv]
// Package: constants shared by the input assembly framer and its testbench.
// Assumes a 20 MHz core clock and an Avalon-MM register bus with waitrequest.
package riaf_pkg;

	// Assembly instance selectors
	localparam logic [7:0] INST_BASIC      = 8'h64;
	localparam logic [7:0] INST_FRAGMENTED = 8'h65;

	// Frame geometry
	localparam int         HDR_BASIC       = 5;
	localparam int         HDR_FRAG        = 9;
	localparam logic [8:0] MAX_LEN_BASIC   = 9'h104;
	localparam logic [8:0] MAX_LEN_FRAG    = 9'h108;
	localparam logic [8:0] MIN_LEN         = 9'h001;
	localparam logic [7:0] MAX_RESULT_LEN  = 8'hff;

	// Register word offsets (byte addresses)
	localparam logic [5:0] REG_CTRL        = 6'h00;
	localparam logic [5:0] REG_FRAME_LEN   = 6'h04;
	localparam logic [5:0] REG_DEV_STATUS  = 6'h08;
	localparam logic [5:0] REG_FLAGS       = 6'h0c;
	localparam logic [5:0] REG_FRAGMENT    = 6'h10;
	localparam logic [5:0] REG_RESULT      = 6'h14;
	localparam logic [5:0] REG_DATA        = 6'h18;
	localparam logic [5:0] REG_EVENT       = 6'h1c;
	localparam logic [5:0] REG_STATUS      = 6'h20;

	// CTRL fields
	localparam int CTRL_ENABLE_BIT   = 0;
	localparam int CTRL_INST_LSB     = 8;
	localparam int CTRL_SEND_BIT     = 1;

	// Device status byte fields
	localparam int DS_OWNED_BIT      = 0;
	localparam int DS_CONFIG_BIT     = 2;
	localparam int DS_EXT_LSB        = 4;
	localparam logic [7:0] DS_MASK   = 8'hf5;

	// Flag byte fields, bit 0 up
	localparam int FL_STATUS_ACT     = 0;
	localparam int FL_USER_DATA      = 1;
	localparam int FL_MORE_RESULTS   = 2;
	localparam int FL_OVERFLOW       = 3;
	localparam int FL_NEW_RESULT     = 4;
	localparam int FL_WAIT_ACK       = 5;
	localparam logic [7:0] FL_MASK   = 8'h3f;

	// Handshake byte fields (fragmented layout)
	localparam int HS_ACCEPT_BIT     = 0;
	localparam int HS_REJECT_BIT     = 1;
	localparam int HS_ERR_LSB        = 4;

	// Event register bits: writing 1 inverts the matching toggle
	localparam int EV_NEW_RESULT     = 0;
	localparam int EV_ACCEPT         = 1;
	localparam int EV_REJECT         = 2;

	// Cyclic frame period
	localparam int CLK_HZ            = 20000000;
	localparam int CYCLE_US          = 100;
	localparam int CYCLE_CLKS        = (CYCLE_US * (CLK_HZ / 1000000));

	// Reset values
	localparam logic [8:0] RST_FRAME_LEN = 9'h00f;

endpackage

// [hw/riaf_fifo.sv]
// Synchronous FIFO with valid/ready on both sides.
// Assumes a single clock and synchronous active-low reset.
module riaf_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input  wire logic             core_clk_in,
	input  wire logic             rst_n_in,
	input  wire logic [WIDTH-1:0] wr_data_in,
	input  wire logic             wr_valid_in,
	output logic                  wr_ready_out,
	output logic      [WIDTH-1:0] rd_data_out,
	output logic                  rd_valid_out,
	input  wire logic             rd_ready_in,
	output logic [$clog2(DEPTH):0] count_out
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      count;
	wire              push = wr_valid_in && wr_ready_out;
	wire              pop  = rd_valid_out && rd_ready_in;

	assign wr_ready_out = (count != (AW+1)'(DEPTH));
	assign rd_valid_out = (count != '0);
	assign rd_data_out  = mem[rd_ptr];
	assign count_out    = count;

	always_ff @(posedge core_clk_in) begin
		if (push) begin
			mem[wr_ptr] <= wr_data_in;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
			end
			count <= count + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule // riaf_fifo

// [hw/riaf_cycle_timer.sv]
// Divider giving a one-cycle pulse at the cyclic frame rate.
// Assumes the single core clock and synchronous active-low reset.
module riaf_cycle_timer #(
	parameter int PERIOD = 2000
) (
	input  wire logic core_clk_in,
	input  wire logic rst_n_in,
	input  wire logic run_in,
	output logic      tick_out
);
	logic [$clog2(PERIOD+1)-1:0] cnt;
	wire                         at_end = (cnt == ($clog2(PERIOD+1))'(PERIOD - 1));

	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in || !run_in) begin
			cnt      <= '0;
			tick_out <= 1'b0;
		end else begin
			cnt      <= at_end ? '0 : cnt + 1'b1;
			tick_out <= at_end;
		end
	end
endmodule // riaf_cycle_timer

// [hw/riaf_framer.sv]
// Input assembly framer: builds cyclic basic or fragmented frames, streamed byte-wise.
// Assumes an Avalon-MM master for software and a byte sink with ready on the frame side.
// Function
// - Device emits its input assembly cyclically toward the controller.
// - Basic and fragmented input instances selectable; third instance left out.
// - Basic frame length 1 to 260 bytes; frame cut at configured length.
// - Basic: status, result count, flags, result length low then high.
// - Flag bits: activation, user data, more results, overflow, toggle, wait ack.
// - Basic payload begins at frame byte 5, count set by length.
// - Fragmented: status, handshake, fragment fields, count, flags, length bytes 7-8.
// - Fragmented payload begins at frame byte 9, count set by length.
// - Any in-range length accepted; only fitting payload bytes are filled.
// - Status byte: owned bit 0, configured bit 2, extended state bits 4-7.
//
// The implementer's own choices: the placing of the registers and the Avalon-MM slave port.
module riaf_framer #(
	parameter int CYCLE_CLKS = riaf_pkg::CYCLE_CLKS,
	parameter int FIFO_DEPTH = 8
) (
	input  wire logic        core_clk_in,
	input  wire logic        rst_n_in,
	// Avalon-MM slave
	input  wire logic [5:0]  avs_address_in,
	input  wire logic        avs_read_in,
	input  wire logic        avs_write_in,
	input  wire logic [31:0] avs_writedata_in,
	input  wire logic [3:0]  avs_byteenable_in,
	output logic      [31:0] avs_readdata_out,
	output logic             avs_waitrequest_out,
	// Frame byte stream
	output logic      [7:0]  frame_data_out,
	output logic             frame_valid_out,
	output logic             frame_sop_out,
	output logic             frame_eop_out,
	input  wire logic        frame_ready_in
);
	typedef enum logic [1:0] {ST_IDLE, ST_HEAD, ST_DATA} riaf_state_type;

	// Software-owned registers and the sent frame counter
	logic        enable;
	logic        frag_mode;
	logic [8:0]  frame_len;
	logic [7:0]  dev_status;
	logic [7:0]  flags;
	logic        new_result_tgl;
	logic        accept_tgl;
	logic        reject_tgl;
	logic [3:0]  err_code;
	logic [7:0]  frag_num;
	logic [7:0]  frag_remain;
	logic [7:0]  frag_size;
	logic [7:0]  result_cnt;
	logic [15:0] result_len;
	logic [7:0]  payload [256];
	logic [7:0]  data_wptr;
	logic [15:0] frames_sent;

	// Frame builder state
	riaf_state_type state;
	logic [8:0]  byte_idx;
	logic [8:0]  cur_len;
	logic        cur_frag;
	logic [7:0]  cur_byte;
	logic        pend;
	logic        bus_ack;

	// FIFO wiring
	logic        fifo_ready;
	logic [9:0]  fifo_out;
	logic        fifo_valid;
	logic        tick;
	// Output stage pulls a byte when empty or when the sink takes the held one
	wire         out_take = fifo_valid && (!frame_valid_out || frame_ready_in);

	// Bus decode
	wire bus_req    = (avs_read_in || avs_write_in) && !bus_ack;
	wire wr_ctrl    = avs_write_in && bus_req && (avs_address_in == riaf_pkg::REG_CTRL);
	wire wr_len     = avs_write_in && bus_req && (avs_address_in == riaf_pkg::REG_FRAME_LEN);
	wire wr_dstat   = avs_write_in && bus_req && (avs_address_in == riaf_pkg::REG_DEV_STATUS);
	wire wr_flags   = avs_write_in && bus_req && (avs_address_in == riaf_pkg::REG_FLAGS);
	wire wr_frag    = avs_write_in && bus_req && (avs_address_in == riaf_pkg::REG_FRAGMENT);
	wire wr_result  = avs_write_in && bus_req && (avs_address_in == riaf_pkg::REG_RESULT);
	wire wr_data    = avs_write_in && bus_req && (avs_address_in == riaf_pkg::REG_DATA);
	wire wr_event   = avs_write_in && bus_req && (avs_address_in == riaf_pkg::REG_EVENT);
	wire [8:0] wlen = avs_writedata_in[8:0];
	wire [8:0] max_len = frag_mode ? riaf_pkg::MAX_LEN_FRAG : riaf_pkg::MAX_LEN_BASIC;
	// Out-of-range lengths are clamped rather than rejected
	wire [8:0] len_fix = (wlen < riaf_pkg::MIN_LEN) ? riaf_pkg::MIN_LEN :
	                     (wlen > max_len) ? max_len : wlen;

	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0;
		if (avs_address_in == riaf_pkg::REG_CTRL) begin
			rd_mux = {23'h0, frag_mode, 7'h0, enable};
		end else if (avs_address_in == riaf_pkg::REG_FRAME_LEN) begin
			rd_mux = {23'h0, frame_len};
		end else if (avs_address_in == riaf_pkg::REG_DEV_STATUS) begin
			rd_mux = {24'h0, dev_status};
		end else if (avs_address_in == riaf_pkg::REG_FLAGS) begin
			rd_mux = {16'h0, err_code, 1'b0, reject_tgl, accept_tgl, new_result_tgl,
			          flags};
		end else if (avs_address_in == riaf_pkg::REG_FRAGMENT) begin
			rd_mux = {8'h0, frag_size, frag_remain, frag_num};
		end else if (avs_address_in == riaf_pkg::REG_RESULT) begin
			rd_mux = {8'h0, result_cnt, result_len};
		end else if (avs_address_in == riaf_pkg::REG_STATUS) begin
			rd_mux = {frames_sent, 6'h0, (state != ST_IDLE), pend, data_wptr};
		end
	end

	// Each access answered one cycle after it is seen; waitrequest kept in a flop
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			avs_waitrequest_out <= 1'b1;
			avs_readdata_out    <= 32'h0;
		end else begin
			avs_waitrequest_out <= !bus_req;
			avs_readdata_out    <= (avs_read_in && bus_req) ? rd_mux : avs_readdata_out;
		end
	end
	assign bus_ack = !avs_waitrequest_out;

	always_ff @(posedge core_clk_in) begin
		if (wr_data) begin
			payload[data_wptr] <= avs_writedata_in[7:0];
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			enable         <= 1'b0;
			frag_mode      <= 1'b0;
			frame_len      <= riaf_pkg::RST_FRAME_LEN;
			dev_status     <= 8'h00;
			flags          <= 8'h00;
			new_result_tgl <= 1'b0;
			accept_tgl     <= 1'b0;
			reject_tgl     <= 1'b0;
			err_code       <= 4'h0;
			frag_num       <= 8'h00;
			frag_remain    <= 8'h00;
			frag_size      <= 8'h00;
			result_cnt     <= 8'h00;
			result_len     <= 16'h0;
			data_wptr      <= 8'h00;
		end else begin
			if (wr_ctrl) begin
				enable    <= avs_writedata_in[riaf_pkg::CTRL_ENABLE_BIT];
				frag_mode <= (avs_writedata_in[riaf_pkg::CTRL_INST_LSB +: 8] ==
				              riaf_pkg::INST_FRAGMENTED);
			end
			if (wr_len) begin
				frame_len <= len_fix;
			end
			if (wr_dstat) begin
				dev_status <= avs_writedata_in[7:0] & riaf_pkg::DS_MASK;
			end
			if (wr_flags) begin
				flags    <= avs_writedata_in[7:0] & riaf_pkg::FL_MASK & ~8'h10;
				err_code <= avs_writedata_in[15:12];
			end
			if (wr_frag) begin
				frag_num    <= avs_writedata_in[7:0];
				frag_remain <= avs_writedata_in[15:8];
				frag_size   <= avs_writedata_in[23:16];
			end
			if (wr_result) begin
				result_len <= avs_writedata_in[15:0];
				result_cnt <= avs_writedata_in[23:16];
				data_wptr  <= 8'h00;
			end else if (wr_data) begin
				data_wptr <= data_wptr + 8'h01;
			end
			if (wr_event) begin
				new_result_tgl <= new_result_tgl ^ avs_writedata_in[riaf_pkg::EV_NEW_RESULT];
				accept_tgl     <= accept_tgl ^ avs_writedata_in[riaf_pkg::EV_ACCEPT];
				reject_tgl     <= reject_tgl ^ avs_writedata_in[riaf_pkg::EV_REJECT];
			end
		end
	end

	// Frame content selection
	wire [7:0] flag_byte = {2'b00, flags[5], new_result_tgl, flags[3:0]};
	wire [7:0] hs_byte   = {err_code, 2'b00, reject_tgl, accept_tgl};
	wire [8:0] hdr_len   = cur_frag ? 9'(riaf_pkg::HDR_FRAG) : 9'(riaf_pkg::HDR_BASIC);
	wire [8:0] pay_idx   = byte_idx - hdr_len;

	always_comb begin
		cur_byte = payload[pay_idx[7:0]];
		if (!cur_frag) begin
			if (byte_idx == 9'd0) begin
				cur_byte = dev_status;
			end else if (byte_idx == 9'd1) begin
				cur_byte = result_cnt;
			end else if (byte_idx == 9'd2) begin
				cur_byte = flag_byte;
			end else if (byte_idx == 9'd3) begin
				cur_byte = result_len[7:0];
			end else if (byte_idx == 9'd4) begin
				cur_byte = result_len[15:8];
			end
		end else begin
			if (byte_idx == 9'd0) begin
				cur_byte = dev_status;
			end else if (byte_idx == 9'd1) begin
				cur_byte = hs_byte;
			end else if (byte_idx == 9'd2) begin
				cur_byte = frag_num;
			end else if (byte_idx == 9'd3) begin
				cur_byte = frag_remain;
			end else if (byte_idx == 9'd4) begin
				cur_byte = frag_size;
			end else if (byte_idx == 9'd5) begin
				cur_byte = result_cnt;
			end else if (byte_idx == 9'd6) begin
				cur_byte = flag_byte;
			end else if (byte_idx == 9'd7) begin
				cur_byte = result_len[7:0];
			end else if (byte_idx == 9'd8) begin
				cur_byte = result_len[15:8];
			end
		end
	end

	riaf_cycle_timer #(
		.PERIOD (CYCLE_CLKS)
	) u_timer (
		.core_clk_in (core_clk_in),
		.rst_n_in    (rst_n_in),
		.run_in      (enable),
		.tick_out    (tick)
	);

	wire last_byte = (byte_idx == cur_len - 9'd1);
	wire push      = (state != ST_IDLE) && fifo_ready;

	// A tick during a busy frame is remembered; further ticks in the same frame merge into it
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			state       <= ST_IDLE;
			byte_idx    <= 9'd0;
			cur_len     <= riaf_pkg::RST_FRAME_LEN;
			cur_frag    <= 1'b0;
			pend        <= 1'b0;
			frames_sent <= 16'h0;
		end else begin
			pend <= tick || (pend && state != ST_IDLE);
			case (state)
				ST_IDLE: begin
					if (pend || tick) begin
						cur_len  <= frame_len;
						cur_frag <= frag_mode;
						byte_idx <= 9'd0;
						state    <= ST_HEAD;
						pend     <= pend && tick; // Fresh tick outlives the consumed one
					end
				end
				ST_HEAD, ST_DATA: begin
					if (push) begin
						byte_idx <= byte_idx + 9'd1;
						state    <= (byte_idx + 9'd1 >= hdr_len) ? ST_DATA : ST_HEAD;
						if (last_byte) begin
							state       <= ST_IDLE;
							frames_sent <= frames_sent + 16'h1;
						end
					end
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	riaf_fifo #(
		.WIDTH (10),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.core_clk_in  (core_clk_in),
		.rst_n_in     (rst_n_in),
		.wr_data_in   ({(byte_idx == 9'd0), last_byte, cur_byte}),
		.wr_valid_in  (state != ST_IDLE),
		.wr_ready_out (fifo_ready),
		.rd_data_out  (fifo_out),
		.rd_valid_out (fifo_valid),
		.rd_ready_in  (out_take),
		.count_out    ()
	);

	// Output register stage; stalls when the sink holds ready low
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			frame_valid_out <= 1'b0;
			frame_data_out  <= 8'h00;
			frame_sop_out   <= 1'b0;
			frame_eop_out   <= 1'b0;
		end else if (!frame_valid_out || frame_ready_in) begin
			frame_valid_out <= fifo_valid;
			// Stale FIFO words must not raise markers while empty
			frame_sop_out   <= fifo_valid && fifo_out[9];
			frame_eop_out   <= fifo_valid && fifo_out[8];
			frame_data_out  <= fifo_out[7:0];
		end
	end
endmodule // riaf_framer

// [sim/riaf_framer_asserts.sv]
// Checker for the input assembly framer, watching only its top ports.
// Assumes one core clock and the synchronous active-low reset.
module riaf_framer_asserts #(
	parameter int CYCLE_CLKS = 20
) (
	input wire logic        core_clk_in,
	input wire logic        rst_n_in,
	input wire logic [5:0]  avs_address_in,
	input wire logic        avs_read_in,
	input wire logic        avs_write_in,
	input wire logic [31:0] avs_readdata_out,
	input wire logic        avs_waitrequest_out,
	input wire logic [7:0]  frame_data_out,
	input wire logic        frame_valid_out,
	input wire logic        frame_sop_out,
	input wire logic        frame_eop_out,
	input wire logic        frame_ready_in
);
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!rst_n_in);

	logic in_frame;

	// Tracks whether a frame has started but its last byte is not yet taken
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			in_frame <= 1'b0;
		end else if (frame_valid_out && frame_ready_in) begin
			in_frame <= !frame_eop_out;
		end
	end

	sequence s_req_seen;
		(avs_read_in || avs_write_in) && avs_waitrequest_out;
	endsequence

	sequence s_byte_stalled;
		frame_valid_out && !frame_ready_in;
	endsequence

	a_wait_one_cycle: assert property (s_req_seen |=> !avs_waitrequest_out)
		else $error("waitrequest not low one cycle after request");
	a_wait_back_high: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
		else $error("waitrequest low for more than one cycle");
	a_stream_hold: assert property (s_byte_stalled |=> frame_valid_out
		&& $stable(frame_data_out) && $stable(frame_sop_out) && $stable(frame_eop_out))
		else $error("stalled frame byte changed");
	a_sop_with_valid: assert property (frame_sop_out |-> frame_valid_out)
		else $error("start marker without valid");
	a_eop_with_valid: assert property (frame_eop_out |-> frame_valid_out)
		else $error("end marker without valid");
	a_frame_opens_sop: assert property (frame_valid_out && !in_frame |-> frame_sop_out)
		else $error("frame does not open with start marker");
	a_no_mid_sop: assert property (frame_valid_out && in_frame |-> !frame_sop_out)
		else $error("start marker inside a frame");
	a_status_resv_zero: assert property (frame_valid_out && !in_frame
		|-> (frame_data_out & 8'h0a) == 8'h00)
		else $error("reserved status bits set");
	a_reset_outputs: assert property (@(posedge core_clk_in) disable iff (1'b0)
		!rst_n_in |=> avs_waitrequest_out && !frame_valid_out)
		else $error("outputs not at reset level");
	a_unmapped_zero: assert property (avs_read_in && !avs_waitrequest_out
		&& avs_address_in == 6'h24 |-> avs_readdata_out == 32'h00000000)
		else $error("unmapped read not zero");
endmodule // riaf_framer_asserts

bind riaf_framer riaf_framer_asserts #(.CYCLE_CLKS(CYCLE_CLKS)) u_chk (
	.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .avs_address_in(avs_address_in),
	.avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
	.avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
	.frame_data_out(frame_data_out), .frame_valid_out(frame_valid_out),
	.frame_sop_out(frame_sop_out), .frame_eop_out(frame_eop_out),
	.frame_ready_in(frame_ready_in));

// [sim/riaf_sink.sv]
// Controller-side model: takes the cyclic input assembly bytes and keeps the last frame.
// Assumes the framer's byte stream; stalls on a fixed pattern when asked.
module riaf_sink (
	input  wire logic        core_clk_in,
	input  wire logic        rst_n_in,
	input  wire logic        stall_in,
	input  wire logic [7:0]  frame_data_in,
	input  wire logic        frame_valid_in,
	input  wire logic        frame_sop_in,
	input  wire logic        frame_eop_in,
	output logic             frame_ready_out,
	output logic      [15:0] frames_out,
	output logic      [8:0]  len_out
);
	logic [7:0] buf_q [16];
	logic [8:0] idx;
	logic [8:0] pos;
	logic [1:0] phase;

	// Only the first 16 bytes are kept; enough for the frames under test
	assign pos = frame_sop_in ? 9'h000 : idx;

	// Input side only: only frame_ready_out travels back on this path
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			idx <= 9'h000;
			frames_out <= 16'h0000;
			len_out <= 9'h000;
			phase <= 2'h0;
			frame_ready_out <= 1'b0;
		end else begin
			phase <= phase + 2'h1;
			frame_ready_out <= !(stall_in && phase != 2'h3);
			if (frame_valid_in && frame_ready_out) begin
				if (pos < 9'h010) buf_q[pos[3:0]] <= frame_data_in;
				idx <= pos + 9'h001;
				if (frame_eop_in) begin
					len_out <= pos + 9'h001;
					frames_out <= frames_out + 16'h0001;
				end
			end
		end
	end
endmodule // riaf_sink

// [sim/tb_reader_input_assembly_framer.sv]
// Testbench for the input assembly framer: register tasks plus frame checks.
// Assumes the framer, its checker and the controller-side sink model.
module tb_reader_input_assembly_framer;
	timeunit 1ns;
	timeprecision 1ns;

	logic        core_clk_in = 1'b0;
	logic        rst_n_in = 1'b0;
	logic [5:0]  avs_address_in = 6'h00;
	logic        avs_read_in = 1'b0;
	logic        avs_write_in = 1'b0;
	logic [31:0] avs_writedata_in = 32'h00000000;
	logic [31:0] avs_readdata_out;
	logic        avs_waitrequest_out;
	logic [7:0]  frame_data_out;
	logic        frame_valid_out;
	logic        frame_sop_out;
	logic        frame_eop_out;
	logic        frame_ready_in;
	logic        stall = 1'b0;
	logic [15:0] frames;
	logic [8:0]  len;
	logic [31:0] rd;
	int          n_fail = 0;
	int          comparisons = 0;
	int          cyc = 0;

	always #25 core_clk_in = !core_clk_in;

	riaf_framer #(.CYCLE_CLKS(20), .FIFO_DEPTH(8)) dut (
		.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .avs_address_in(avs_address_in),
		.avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
		.avs_writedata_in(avs_writedata_in), .avs_byteenable_in(4'hf),
		.avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
		.frame_data_out(frame_data_out), .frame_valid_out(frame_valid_out),
		.frame_sop_out(frame_sop_out), .frame_eop_out(frame_eop_out),
		.frame_ready_in(frame_ready_in));

	riaf_sink sink (
		.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .stall_in(stall),
		.frame_data_in(frame_data_out), .frame_valid_in(frame_valid_out),
		.frame_sop_in(frame_sop_out), .frame_eop_in(frame_eop_out),
		.frame_ready_out(frame_ready_in), .frames_out(frames), .len_out(len));

	task automatic results();
		if (n_fail == 0 && comparisons > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			$display("Error %s expected %h seen %h", nm, exp, got);
			n_fail++;
		end
	endtask

	// Request held until the edge where waitrequest is seen low
	task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
		@(posedge core_clk_in);
		avs_address_in <= a;
		avs_writedata_in <= d;
		avs_write_in <= wr;
		avs_read_in <= !wr;
		do @(posedge core_clk_in); while (avs_waitrequest_out !== 1'b0);
		rd = avs_readdata_out;
		avs_write_in <= 1'b0;
		avs_read_in <= 1'b0;
	endtask

	task automatic wait_frames(input int n);
		logic [15:0] target;
		target = frames + 16'(n);
		while (frames != target) @(posedge core_clk_in);
	endtask

	// Expected bytes given byte 0 first, left aligned in e
	task automatic chk_frame(input int n, input logic [95:0] e);
		// Up to three frames may be queued or latched before the last write
		wait_frames(4);
		chk("frame_len", 32'(n), 32'(len));
		for (int i = 0; i < n; i++) chk("frame_byte", 32'(e[95-8*i -: 8]), 32'(sink.buf_q[i]));
	endtask

	always @(posedge core_clk_in) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			results();
		end
	end

	initial begin
		repeat (5) @(posedge core_clk_in);
		rst_n_in <= 1'b1;
		bus(1'b0, riaf_pkg::REG_FRAME_LEN, 32'h0); chk("len_rst", 32'h0000000f, rd);
		bus(1'b0, 6'h24, 32'h0); chk("unmapped", 32'h0, rd);
		bus(1'b1, 6'h24, 32'hffffffff);
		bus(1'b1, riaf_pkg::REG_FRAME_LEN, 32'h1ff);
		bus(1'b0, riaf_pkg::REG_FRAME_LEN, 32'h0); chk("len_max", 32'h00000104, rd);
		bus(1'b1, riaf_pkg::REG_DEV_STATUS, 32'hff);
		bus(1'b1, riaf_pkg::REG_FLAGS, 32'h3f);
		bus(1'b1, riaf_pkg::REG_RESULT, 32'h00020003);
		bus(1'b1, riaf_pkg::REG_DATA, 32'ha1);
		bus(1'b1, riaf_pkg::REG_DATA, 32'hb2);
		bus(1'b1, riaf_pkg::REG_DATA, 32'hc3);
		bus(1'b1, riaf_pkg::REG_FRAME_LEN, 32'd8);
		stall <= 1'b1;
		bus(1'b1, riaf_pkg::REG_CTRL, 32'h6401);
		chk_frame(8, 96'hf5022f0300a1b2c300000000);
		bus(1'b1, riaf_pkg::REG_EVENT, 32'h1);
		chk_frame(8, 96'hf5023f0300a1b2c300000000);
		bus(1'b1, riaf_pkg::REG_FRAME_LEN, 32'd1);
		chk_frame(1, 96'hf50000000000000000000000);
		bus(1'b1, riaf_pkg::REG_CTRL, 32'h6501);
		bus(1'b1, riaf_pkg::REG_FRAME_LEN, 32'h1ff);
		bus(1'b0, riaf_pkg::REG_FRAME_LEN, 32'h0); chk("len_fmax", 32'h00000108, rd);
		bus(1'b1, riaf_pkg::REG_FRAME_LEN, 32'h0);
		bus(1'b0, riaf_pkg::REG_FRAME_LEN, 32'h0); chk("len_min", 32'h00000001, rd);
		bus(1'b1, riaf_pkg::REG_FRAGMENT, 32'h00030201);
		bus(1'b1, riaf_pkg::REG_FLAGS, 32'ha03f);
		bus(1'b1, riaf_pkg::REG_EVENT, 32'h6);
		bus(1'b1, riaf_pkg::REG_FRAME_LEN, 32'd12);
		chk_frame(12, 96'hf5a3010203023f0300a1b2c3);
		stall <= 1'b0;
		bus(1'b1, riaf_pkg::REG_EVENT, 32'h2);
		chk_frame(12, 96'hf5a2010203023f0300a1b2c3);
		bus(1'b1, riaf_pkg::REG_CTRL, 32'h6500);
		// Let a frame already started or queued drain first
		repeat (60) @(posedge core_clk_in);
		rd = 32'(frames);
		repeat (80) @(posedge core_clk_in);
		chk("frames_stop", rd, 32'(frames));
		results();
	end
endmodule // tb_reader_input_assembly_framer
